// ===== rtl/fvu_defines.vh
`ifndef FVU_DEFINES_VH
`define FVU_DEFINES_VH

// command codes
`define FVU_CMD_VERIFY_SECTION 8'h03
`define FVU_CMD_READ_ONCE      8'h04
`define FVU_CMD_ERASE_SECTOR   8'h0A
`define FVU_CMD_UNSECURE       8'h0B

// slot index expected at launch for each command
`define FVU_IDX_VERIFY_SECTION 3'h2
`define FVU_IDX_READ_ONCE      3'h0
`define FVU_IDX_ERASE_SECTOR   3'h1
`define FVU_IDX_UNSECURE       3'h0

// memory geometry, in phrases (8 bytes each)
`define FVU_PHRASE_BITS        3
`define FVU_PROG_PHRASES       15'h3000
`define FVU_DATA_PHRASES       15'h0100
`define FVU_ONCE_PHRASES       4'h8
`define FVU_SECTOR_PHRASES     15'h0040
`define FVU_PROG_BASE_HI       2'h0

// wait in clock cycles before the erase pass starts
`define FVU_ERASE_CYCLES       16'h0010

`endif

// ===== rtl/fvu_launch_check.v
`timescale 1ns/1ps
`include "fvu_defines.vh"
// combinational launch screening for access and protection errors
module fvu_launch_check (
  cmdCode,
  slotIndex,
  addrHi,
  addrLo,
  phraseCount,
  modeAllowed,
  protProg,
  protData,
  sectorProt,
  accessErr,
  protErr
);
  input  wire [7:0]  cmdCode;
  input  wire [2:0]  slotIndex;
  input  wire [1:0]  addrHi;
  input  wire [15:0] addrLo;
  input  wire [15:0] phraseCount;
  input  wire        modeAllowed;
  input  wire        protProg;
  input  wire        protData;
  input  wire        sectorProt;
  output reg         accessErr;
  output reg         protErr;

  reg [17:0] gAddr;
  reg [15:0] firstPh;
  reg [16:0] endPh;

  always @* begin
    gAddr     = {addrHi, addrLo};
    firstPh   = {1'b0, gAddr[17:3]};
    endPh     = {1'b0, firstPh} + {1'b0, phraseCount};
    accessErr = 1'b0;
    protErr   = 1'b0;
    if (!modeAllowed) begin
      accessErr = 1'b1;
    end
    if (cmdCode == `FVU_CMD_VERIFY_SECTION) begin
      if (slotIndex != `FVU_IDX_VERIFY_SECTION) accessErr = 1'b1;
      // address in map; the full 18-bit address counts here
      if (firstPh >= {1'b0, `FVU_PROG_PHRASES}) accessErr = 1'b1;
      if (gAddr[2:0] != 3'h0) accessErr = 1'b1;
      if (endPh > {2'h0, `FVU_PROG_PHRASES}) accessErr = 1'b1;
    end else if (cmdCode == `FVU_CMD_ERASE_SECTOR) begin
      if (slotIndex != `FVU_IDX_ERASE_SECTOR) accessErr = 1'b1;
      if (addrHi != `FVU_PROG_BASE_HI ||
          firstPh >= {1'b0, `FVU_PROG_PHRASES}) accessErr = 1'b1;
      if (gAddr[2:0] != 3'h0) accessErr = 1'b1;
      if (sectorProt) protErr = 1'b1;
    end else if (cmdCode == `FVU_CMD_UNSECURE) begin
      if (slotIndex != `FVU_IDX_UNSECURE) accessErr = 1'b1;
      if (protProg || protData) protErr = 1'b1;
    end else if (cmdCode == `FVU_CMD_READ_ONCE) begin
      if (slotIndex != `FVU_IDX_READ_ONCE) accessErr = 1'b1;
    end else begin
      accessErr = 1'b1;
    end
  end
endmodule

// ===== rtl/fvu_phrase_mem.v
`timescale 1ns/1ps
// phrase store: one erased/clean flag pair per phrase, registered read
module fvu_phrase_mem (
  mclk,
  rdAddr,
  rdData,
  wrEn,
  wrAddr,
  wrData
);
  input  wire        mclk;
  input  wire [14:0] rdAddr;
  output reg  [1:0]  rdData;  // {read error, blank}
  input  wire        wrEn;
  input  wire [14:0] wrAddr;
  input  wire [1:0]  wrData;

  // no reset on the array, like real storage
  reg [1:0] mem [0:16383];

  // registered read port
  always @(posedge mclk) begin
    rdData <= mem[rdAddr[13:0]];
    if (wrEn) begin
      mem[wrAddr[13:0]] <= wrData;
    end
  end
endmodule

// ===== rtl/fvu_sequencer.v
// What this block does
// - section verify checks every phrase erased
// - complete flag sets after section verify
// - non-erased phrase in section verify sets both verify bits
// - section verify needs slot index two
// - command barred in mode gives access error
// - address outside map gives access error
// - unaligned phrase address gives access error
// - section crossing boundary gives access error
// - upper bit on read error or fail
// - lower bit on fail in section verify, on read error with fail in erase and unsecure
// - read once serves eight reserved phrases
// - sector erase needs slot index one
// - protected sector sets protection flag
// - sector erase verify errors set bits
// - unsecure erases, verifies, then releases security
// - failed unsecure sets upper, keeps security
// - unsecure needs slot index zero
// - program or data protection flags unsecure violation; the sector mask is not checked
// - complete flag sets after unsecure
// - new command only after previous completes
`timescale 1ns/1ps
`include "fvu_defines.vh"
module fvu_sequencer (
  mclk,
  nrst,
  objWrite,
  objIndex,
  objData,
  launch,
  modeAllowed,
  protProg,
  protData,
  protSectorMask,
  onceData,
  onceValid,
  commandCompleteFlag,
  accessErrorFlag,
  protectionViolationFlag,
  verifyStatusUpper,
  verifyStatusLower,
  secureState,
  commandSlotIndex
);
  input  wire        mclk;
  input  wire        nrst;
  input  wire        objWrite;        // write one command object slot
  input  wire [2:0]  objIndex;        // slot written by objWrite
  input  wire [15:0] objData;         // slot data
  input  wire        launch;          // pulse: clear complete flag
  input  wire        modeAllowed;     // command allowed in current mode
  input  wire        protProg;        // some program region protected
  input  wire        protData;        // some data region protected
  input  wire [31:0] protSectorMask;  // protect bit per 2 kB window, low 64 kB
  output reg  [1:0]  onceData;        // read-once phrase status word
  output reg         onceValid;       // one-cycle pulse per phrase
  output reg         commandCompleteFlag;
  output reg         accessErrorFlag;
  output reg         protectionViolationFlag;
  output reg         verifyStatusUpper;
  output reg         verifyStatusLower;
  output reg         secureState;     // 1 while device is secured
  output reg  [2:0]  commandSlotIndex;

  // state codes
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_VERIFY = 3'h1;
  localparam [2:0] ST_ERASE  = 3'h2;
  localparam [2:0] ST_ONCE   = 3'h3;
  localparam [2:0] ST_DONE   = 3'h4;

  reg  [15:0] slot0_q;          // command code and address high
  reg  [15:0] slot1_q;          // address low
  reg  [15:0] slot2_q;          // phrase count
  reg  [2:0]  state_q;
  reg  [14:0] addr_q;           // current phrase
  reg  [14:0] last_q;           // last phrase of pass
  reg  [15:0] wait_q;           // erase timer
  reg         rdPend_q;         // read data due this cycle
  reg         lastRd_q;         // last phrase address already read
  reg  [1:0]  accum_q;          // {any read err, any not blank}

  wire [1:0]  rdData;
  wire        access_error_flag;
  wire        pvErr;
  wire [7:0]  cmdCode = slot0_q[15:8];
  wire [4:0]  sectIdx = slot1_q[15:11];
  reg         memWe;
  reg  [14:0] memRa;

  // phrase number of a global address held in slots zero and one
  function [14:0] phraseOf;
    input [1:0]  hiBits;
    input [15:0] loWord;
    begin
      phraseOf = {hiBits, loWord[15:3]};
    end
  endfunction

  // first phrase of the 64-phrase erase sector holding an address;
  // sector erase only reaches the low 64 kB, so the high bits are zero
  function [14:0] sectorBase;
    input [15:0] loWord;
    begin
      sectorBase = {2'h0, loWord[15:9], 6'h00};
    end
  endfunction

  // one protect bit per 2 kB window of the low address word; coarser
  // than an erase sector, so one protect bit covers four sectors
  wire        sectProt = protSectorMask[sectIdx];

  fvu_launch_check uCheck (
    .cmdCode     (cmdCode),
    .slotIndex   (commandSlotIndex),
    .addrHi      (slot0_q[1:0]),
    .addrLo      (slot1_q),
    .phraseCount (slot2_q),
    .modeAllowed (modeAllowed),
    .protProg    (protProg),
    .protData    (protData),
    .sectorProt  (sectProt),
    .accessErr   (access_error_flag),
    .protErr     (pvErr)
  );

  // write port marks phrases erased during the erase pass
  always @* begin
    memWe = (state_q == ST_ERASE) && (wait_q == 16'h0000);
    memRa = addr_q;
  end

  fvu_phrase_mem uMem (
    .mclk   (mclk),
    .rdAddr (memRa),
    .rdData (rdData),
    .wrEn   (memWe),
    .wrAddr (addr_q),
    .wrData (2'h1)
  );

  // command object load; ignored while busy so a running command
  // cannot be corrupted
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      slot0_q          <= 16'h0000;
      slot1_q          <= 16'h0000;
      slot2_q          <= 16'h0000;
      commandSlotIndex <= 3'h0;
    end else if (objWrite && commandCompleteFlag) begin
      commandSlotIndex <= objIndex;
      if (objIndex == 3'h0) begin
        slot0_q <= objData;
      end else if (objIndex == 3'h1) begin
        slot1_q <= objData;
      end else if (objIndex == 3'h2) begin
        slot2_q <= objData;
      end
    end
  end

  // main sequencer
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q                 <= ST_IDLE;
      commandCompleteFlag     <= 1'b1;
      accessErrorFlag         <= 1'b0;
      protectionViolationFlag <= 1'b0;
      verifyStatusUpper       <= 1'b0;
      verifyStatusLower       <= 1'b0;
      secureState             <= 1'b1;
      addr_q                  <= 15'h0000;
      last_q                  <= 15'h0000;
      wait_q                  <= 16'h0000;
      rdPend_q                <= 1'b0;
      lastRd_q                <= 1'b0;
      accum_q                 <= 2'h0;
      onceData                <= 2'h0;
      onceValid               <= 1'b0;
    end else begin
      onceValid <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (launch && commandCompleteFlag) begin
            commandCompleteFlag     <= 1'b0;
            accessErrorFlag         <= access_error_flag;
            protectionViolationFlag <= pvErr;
            verifyStatusUpper       <= 1'b0;
            verifyStatusLower       <= 1'b0;
            accum_q                 <= 2'h0;
            // clear the read pipeline left by the previous command
            rdPend_q                <= 1'b0;
            lastRd_q                <= 1'b0;
            wait_q                  <= `FVU_ERASE_CYCLES;
            if (access_error_flag || pvErr) begin
              state_q <= ST_DONE;
            end else if (cmdCode == `FVU_CMD_VERIFY_SECTION) begin
              // walk the section
              // a zero count finishes at once with both bits clear
              addr_q  <= phraseOf(slot0_q[1:0], slot1_q);
              last_q  <= phraseOf(slot0_q[1:0], slot1_q) + slot2_q[14:0] -
                         15'h0001;
              state_q <= (slot2_q == 16'h0000) ? ST_DONE : ST_VERIFY;
            end else if (cmdCode == `FVU_CMD_ERASE_SECTOR) begin
              // one sector: erase pass, then verify the same phrases
              addr_q  <= sectorBase(slot1_q);
              last_q  <= sectorBase(slot1_q) + `FVU_SECTOR_PHRASES -
                         15'h0001;
              state_q <= ST_ERASE;
            end else if (cmdCode == `FVU_CMD_UNSECURE) begin
              addr_q  <= 15'h0000;
              last_q  <= `FVU_PROG_PHRASES + `FVU_DATA_PHRASES - 15'h0001;
              state_q <= ST_ERASE;
            end else begin
              // eight reserved phrases past the data area
              addr_q  <= `FVU_PROG_PHRASES + `FVU_DATA_PHRASES;
              last_q  <= `FVU_PROG_PHRASES + `FVU_DATA_PHRASES +
                         {11'h000, `FVU_ONCE_PHRASES} - 15'h0001;
              state_q <= ST_ONCE;
            end
          end
        end
        ST_ERASE: begin
          // erase pass: wait, then mark each phrase erased
          if (wait_q != 16'h0000) begin
            wait_q <= wait_q - 16'h0001;
          end else if (addr_q == last_q) begin
            // rewind to the first phrase for the verify pass
            addr_q  <= (cmdCode == `FVU_CMD_UNSECURE) ? 15'h0000 :
                       sectorBase(slot1_q);
            state_q <= ST_VERIFY;
          end else begin
            addr_q <= addr_q + 15'h0001;
          end
        end
        ST_VERIFY: begin
          // read data trail the address by one cycle, so the pass ends
          // only once the data of the last phrase have come back
          rdPend_q <= 1'b1;
          lastRd_q <= (addr_q == last_q);
          if (rdPend_q) begin
            // fold each phrase into the result
            accum_q <= accum_q | {rdData[1], ~rdData[0]};
          end
          if (addr_q != last_q) begin
            addr_q <= addr_q + 15'h0001;
          end else if (lastRd_q) begin
            state_q <= ST_DONE;
          end
        end
        ST_ONCE: begin
          // same read pipeline, one status pulse per phrase
          rdPend_q <= 1'b1;
          lastRd_q <= (addr_q == last_q);
          if (rdPend_q) begin
            onceData  <= rdData;
            onceValid <= 1'b1;
          end
          if (addr_q != last_q) begin
            addr_q <= addr_q + 15'h0001;
          end else if (lastRd_q) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          // status bits move only here and at launch, so they stand idle
          if (cmdCode == `FVU_CMD_VERIFY_SECTION && !accessErrorFlag) begin
            verifyStatusUpper <= accum_q[1] | accum_q[0];
            verifyStatusLower <= accum_q[0];
          end else if (cmdCode == `FVU_CMD_ERASE_SECTOR) begin
            verifyStatusUpper <= accum_q[1] | accum_q[0];
            verifyStatusLower <= accum_q[1] & accum_q[0];
          end else if (cmdCode == `FVU_CMD_UNSECURE) begin
            verifyStatusUpper <= accum_q[1] | accum_q[0];
            verifyStatusLower <= accum_q[1] & accum_q[0];
            if (!accessErrorFlag && !protectionViolationFlag &&
                accum_q == 2'h0) begin
              secureState <= 1'b0;
            end
          end
          commandCompleteFlag <= 1'b1;
          state_q             <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== verification/fvu_sequencer_checker.sv
`timescale 1ns/1ps
// timing relations between launch, completion and the status flags
module fvu_sequencer_checker (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       objWrite,
  input wire logic [2:0] objIndex,
  input wire logic       launch,
  input wire logic       commandCompleteFlag,
  input wire logic       accessErrorFlag,
  input wire logic       protectionViolationFlag,
  input wire logic       verifyStatusUpper,
  input wire logic       verifyStatusLower,
  input wire logic       secureState,
  input wire logic [2:0] commandSlotIndex
);
  // one clock domain, so clock and reset are given once
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_launch_taken:
    assert property (launch && commandCompleteFlag |=> !commandCompleteFlag)
    else $error("launch did not start a command");
  a_access_prompt:
    assert property (accessErrorFlag && !commandCompleteFlag
      |-> ##[1:3] commandCompleteFlag)
    else $error("access error did not end command promptly");
  a_prot_prompt:
    assert property (protectionViolationFlag && !commandCompleteFlag
      |-> ##[1:3] commandCompleteFlag)
    else $error("protection error did not end command promptly");
  // flags stand while idle so software can read them late
  a_flags_stand:
    assert property (commandCompleteFlag && !launch |=> $stable({
      accessErrorFlag, protectionViolationFlag, verifyStatusUpper,
      verifyStatusLower}))
    else $error("status flags changed while idle");
  a_slot_tracks:
    assert property (objWrite && commandCompleteFlag
      |=> commandSlotIndex == $past(objIndex))
    else $error("slot index not updated");
  a_secure_no_rise:
    assert property (!$rose(secureState))
    else $error("security set again outside reset");
  a_release_clean:
    assert property ($fell(secureState)
      |-> !verifyStatusUpper && !accessErrorFlag)
    else $error("security released despite error");
  a_lower_upper:
    assert property (verifyStatusLower |-> verifyStatusUpper)
    else $error("lower verify bit without upper");
endmodule

bind fvu_sequencer fvu_sequencer_checker fvu_sequencer_checker_i (
  .mclk(mclk), .nrst(nrst), .objWrite(objWrite), .objIndex(objIndex),
  .launch(launch), .commandCompleteFlag(commandCompleteFlag),
  .accessErrorFlag(accessErrorFlag),
  .protectionViolationFlag(protectionViolationFlag),
  .verifyStatusUpper(verifyStatusUpper),
  .verifyStatusLower(verifyStatusLower),
  .secureState(secureState), .commandSlotIndex(commandSlotIndex));

// ===== verification/fvu_sequencer_tb_top.sv
`timescale 1ns/1ps
module fvu_sequencer_tb_top;
  reg         mclk, nrst, objWrite, launch;
  reg         modeAllowed, protProg, protData;
  reg  [2:0]  objIndex;
  reg  [15:0] objData, lo, cnt;
  reg  [1:0]  hi;
  reg  [31:0] protSectorMask;
  wire [1:0]  onceData;
  wire        onceValid, commandCompleteFlag, accessErrorFlag;
  wire        protectionViolationFlag, verifyStatusUpper;
  wire        verifyStatusLower, secureState;
  wire [2:0]  commandSlotIndex;
  integer     errors, nChecks, pulses, k;

  fvu_sequencer fvu_sequencer_i (
    .mclk(mclk), .nrst(nrst), .objWrite(objWrite), .objIndex(objIndex),
    .objData(objData), .launch(launch), .modeAllowed(modeAllowed),
    .protProg(protProg), .protData(protData),
    .protSectorMask(protSectorMask), .onceData(onceData),
    .onceValid(onceValid), .commandCompleteFlag(commandCompleteFlag),
    .accessErrorFlag(accessErrorFlag),
    .protectionViolationFlag(protectionViolationFlag),
    .verifyStatusUpper(verifyStatusUpper),
    .verifyStatusLower(verifyStatusLower), .secureState(secureState),
    .commandSlotIndex(commandSlotIndex));

  // 25 MHz bus clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task check(input [15:0] seen, input [15:0] exp);
    begin
      nChecks = nChecks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // flags packed as {access, protection, upper, lower}
  task flags(input [3:0] e);
    check({12'h000, accessErrorFlag, protectionViolationFlag,
      verifyStatusUpper, verifyStatusLower}, {12'h000, e});
  endtask

  task put(input [2:0] i, input [15:0] d);
    begin
      @(negedge mclk);
      objWrite = 1'b1;
      objIndex = i;
      objData = d;
      @(negedge mclk);
      objWrite = 1'b0;
    end
  endtask

  // load n slots, launch, wait bounded for completion, count phrases
  task run(input [7:0] c, input [1:0] h, input [15:0] a,
    input [15:0] n2, input integer n);
    integer t;
    begin
      put(3'h0, {c, 6'h00, h});
      if (n > 1) put(3'h1, a);
      if (n > 2) put(3'h2, n2);
      @(negedge mclk);
      launch = 1'b1;
      @(negedge mclk);
      launch = 1'b0;
      pulses = 0;
      t = 0;
      while (commandCompleteFlag !== 1'b1 && t < 40000) begin
        if (onceValid === 1'b1) pulses = pulses + 1;
        @(negedge mclk);
        t = t + 1;
      end
      if (onceValid === 1'b1) pulses = pulses + 1;
      if (t >= 40000) errors = errors + 1;
    end
  endtask

  // section verify is refused when unaligned, outside or crossing
  function vacc(input [1:0] h, input [15:0] a, input [15:0] n2);
    integer ph;
    begin
      ph = {h, a[15:3]};
      vacc = (a[2:0] != 3'h0) || (ph >= 32'h00003000) ||
        (ph + n2 > 32'h00003000);
    end
  endfunction

  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", nChecks, errors);
      if (errors == 0 && nChecks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // hang guard, well beyond the long unsecure erase
  initial begin
    #3800000;
    errors = errors + 1;
    tally_and_finish;
  end

  initial begin
    {nrst, objWrite, launch, protProg, protData} = 5'h00;
    {objIndex, objData, protSectorMask} = 51'h0;
    modeAllowed = 1'b1;
    errors = 0;
    nChecks = 0;
    k = $urandom(32'h689DF59E);
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    check({secureState, commandCompleteFlag, commandSlotIndex}, 5'h18);
    flags(4'h0);
    protProg = 1'b1;
    run(8'h0B, 2'h0, 16'h0000, 16'h0000, 1);
    flags(4'h4);
    protProg = 1'b0;
    protData = 1'b1;
    run(8'h0B, 2'h0, 16'h0000, 16'h0000, 1);
    flags(4'h4);
    protData = 1'b0;
    run(8'h0B, 2'h0, 16'h0000, 16'h0000, 2);
    flags(4'h8);
    modeAllowed = 1'b0;
    run(8'h0B, 2'h0, 16'h0000, 16'h0000, 1);
    flags(4'h8);
    modeAllowed = 1'b1;
    check({15'h0000, secureState}, 16'h0001);
    run(8'h0B, 2'h0, 16'h0000, 16'h0000, 1);
    flags(4'h0);
    check({15'h0000, secureState}, 16'h0000);
    // random sections with the boundary cases mixed in
    for (k = 0; k < 16; k = k + 1) begin
      hi = $urandom % 3;
      lo = $urandom;
      cnt = $urandom % 24;
      if (k[0]) lo[2:0] = 3'h0;
      case (k)
        0: {hi, lo, cnt} = {2'h1, 16'h7FF8, 16'h0002};
        2: {hi, lo, cnt} = {2'h1, 16'h7FF8, 16'h0001};
        4: {hi, lo, cnt} = {2'h0, 16'h0100, 16'h0000};
        6: {hi, lo, cnt} = {2'h0, 16'h0004, 16'h0001};
        default: ;
      endcase
      run(8'h03, hi, lo, cnt, 3);
      flags({vacc(hi, lo, cnt), 3'h0});
    end
    run(8'h03, 2'h0, 16'h0000, 16'h0001, 2);
    flags(4'h8);
    // one dirty phrase as the last of a three-phrase section
    fvu_sequencer_i.uMem.mem[16] = 2'h0;
    run(8'h03, 2'h0, 16'h0070, 16'h0003, 3);
    flags(4'h3);
    fvu_sequencer_i.uMem.mem[16] = 2'h3;
    run(8'h03, 2'h0, 16'h0070, 16'h0003, 3);
    flags(4'h2);
    // erasing sector zero must make the section blank again
    protSectorMask = 32'h00000000;
    run(8'h0A, 2'h0, 16'h0000, 16'h0000, 2);
    flags(4'h0);
    run(8'h03, 2'h0, 16'h0070, 16'h0003, 3);
    flags(4'h0);
    // sector erase against a random protection mask
    for (k = 0; k < 4; k = k + 1) begin
      protSectorMask = $urandom;
      lo = $urandom & 16'hFFF8;
      run(8'h0A, 2'h0, lo, 16'h0000, 2);
      flags({1'b0, protSectorMask[lo[15:11]], 2'h0});
    end
    protSectorMask = 32'h00000000;
    run(8'h0A, 2'h0, 16'h0800, 16'h0000, 1);
    flags(4'h8);
    // known pattern in the reserved phrases past the data area
    for (k = 0; k < 8; k = k + 1) begin
      fvu_sequencer_i.uMem.mem[32'h00003100 + k] = k[1:0];
    end
    run(8'h04, 2'h0, 16'h0000, 16'h0000, 1);
    check(pulses[15:0], 16'h0008);
    check({14'h0000, onceData}, 16'h0003);
    run(8'h55, 2'h0, 16'h0000, 16'h0000, 1);
    flags(4'h8);
    tally_and_finish;
  end
endmodule
